// >>> hdl/vst_params.svh
// Timing and position constants for the video sync timing block.
// Assumes a 100 MHz core clock and a slicer sample clock of its own.
`ifndef VST_PARAMS_SVH
`define VST_PARAMS_SVH
`define VST_CLK_MHZ 100
`define VST_NS2CYC(ns) (((((ns) * `VST_CLK_MHZ)) + 999) / 1000)
`define VST_PIN_IDLE 1'b1
`define VST_HS_SD_NS 4700
`define VST_HS_ED_NS 2300
`define VST_HS_HD_NS 475
`define VST_HS_SD_CYC `VST_NS2CYC(`VST_HS_SD_NS)
`define VST_HS_ED_CYC `VST_NS2CYC(`VST_HS_ED_NS)
`define VST_HS_HD_CYC `VST_NS2CYC(`VST_HS_HD_NS)
`define VST_BP_WIDE_NS 2500
`define VST_BP_SHORT_NS 350
`define VST_BP_HD_NS 300
`define VST_BP_WIDE_CYC `VST_NS2CYC(`VST_BP_WIDE_NS)
`define VST_BP_SHORT_CYC `VST_NS2CYC(`VST_BP_SHORT_NS)
`define VST_BP_HD_CYC `VST_NS2CYC(`VST_BP_HD_NS)
`define VST_BPD_SD_NS 500
`define VST_BPD_HD_NS 300
`define VST_BPD_SD_CYC `VST_NS2CYC(`VST_BPD_SD_NS)
`define VST_BPD_HD_CYC `VST_NS2CYC(`VST_BPD_HD_NS)
`define VST_ED_LINE_NS 48000
`define VST_ED_LINE_CYC `VST_NS2CYC(`VST_ED_LINE_NS)
`define VST_VINT_LINES 4'h9
`define VST_LOCK_FIELDS 2'h2
`define VST_FIRST_BIT 4'h3
`define VST_LAST_BIT 4'hD
`endif

// >>> hdl/vst_pkg.sv
// Types shared by the video sync timing block.
// Assumes the constants header is compiled alongside.
package vst_pkg;
    // Slicer comparator levels, all active high
    typedef struct packed {
        logic present;
        logic comp;
        logic ref50;
        logic tri_pos;
    } vst_slice_t;
    typedef struct packed {
        logic composite_sync_pin;
        logic line_sync_pin;
        logic field_sync_pin;
        logic back_porch_gate_pin;
        logic field_parity_pin;
        logic line_count_serial_pin;
    } vst_pins_t;
    typedef enum logic [2:0] {VST_SD = 3'b001, VST_ED = 3'b010, VST_HD = 3'b100} vst_fmt_t;
    typedef enum logic [2:0] {BP_IDLE = 3'b001, BP_WAIT = 3'b010, BP_LOW = 3'b100} vst_bp_t;
endpackage

// >>> hdl/vst_sync_timing.sv
// Sync timing outputs: line, field, composite, porch, parity and line count.
// Assumes comparator levels from an analog slicer, asynchronous to both clocks.
`timescale 1ns/1ns
`default_nettype none
`include "vst_params.svh"

module vst_sync_timing (
    input wire logic clk,
    input wire logic resetn,
    input wire logic slicer_clk,
    input wire vst_pkg::vst_slice_t slice_in,
    output wire vst_pkg::vst_pins_t pins,
    output logic sync_locked
);

    // ****************************************
    // Slicer clock domain
    // ****************************************
    vst_pkg::vst_slice_t s1_r;
    vst_pkg::vst_slice_t s2_r;
    vst_pkg::vst_slice_t s3_r;
    vst_pkg::vst_slice_t filt_r;

    // Two agreeing samples move a bit: drops single-sample comparator chatter
    always_ff @(posedge slicer_clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            filt_r <= '0;
        end else begin
            s1_r <= slice_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
        end
    end

    // ****************************************
    // Crossing into the core clock
    // ****************************************
    vst_pkg::vst_slice_t x1_r;
    vst_pkg::vst_slice_t x2_r;
    vst_pkg::vst_slice_t x3_r;

    // Levels only, so a plain two-stage synchroniser per bit is enough
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            x1_r <= '0;
            x2_r <= '0;
            x3_r <= '0;
        end else begin
            x1_r <= filt_r;
            x2_r <= x1_r;
            x3_r <= x2_r;
        end
    end

    logic present_s;
    logic ref_edge;
    logic comp_trail;
    logic tri_trail;
    assign present_s = x2_r.present;
    assign ref_edge = x2_r.ref50 & ~x3_r.ref50;
    assign comp_trail = ~x2_r.comp & x3_r.comp;
    assign tri_trail = ~x2_r.tri_pos & x3_r.tri_pos;

    // ****************************************
    // Decoding helpers
    // ****************************************
    function automatic logic [11:0] hs_width(input vst_pkg::vst_fmt_t f);
        case (f)
            vst_pkg::VST_HD: hs_width = 12'(`VST_HS_HD_CYC);
            vst_pkg::VST_ED: hs_width = 12'(`VST_HS_ED_CYC);
            default: hs_width = 12'(`VST_HS_SD_CYC);
        endcase
    endfunction

    function automatic logic [11:0] bp_width(input vst_pkg::vst_fmt_t f, input logic vint);
        case (f)
            vst_pkg::VST_HD: bp_width = 12'(`VST_BP_HD_CYC);
            vst_pkg::VST_ED: bp_width = 12'(`VST_BP_SHORT_CYC);
            default: bp_width = vint ? 12'(`VST_BP_SHORT_CYC) : 12'(`VST_BP_WIDE_CYC);
        endcase
    endfunction

    function automatic logic [11:0] bp_delay(input vst_pkg::vst_fmt_t f);
        case (f)
            vst_pkg::VST_HD: bp_delay = 12'(`VST_BPD_HD_CYC);
            default: bp_delay = 12'(`VST_BPD_SD_CYC);
        endcase
    endfunction

    // ****************************************
    // Line period tracking
    // ****************************************
    logic [13:0] since_ref_r;
    logic [13:0] line_len_r;
    logic tri_seen_r;
    logic accept;
    logic sat;
    vst_pkg::vst_fmt_t fmt_r;
    vst_pkg::vst_fmt_t fmt_nxt;

    // Half-line equalising pulses land early and are skipped
    assign sat = (since_ref_r == 14'h3FFF);
    assign accept = present_s & ref_edge & ((line_len_r == 14'h0000) | sat |
                    (since_ref_r > (line_len_r - (line_len_r >> 2))));

    always_comb begin
        if (tri_seen_r) begin
            fmt_nxt = vst_pkg::VST_HD;
        end else if (since_ref_r < 14'(`VST_ED_LINE_CYC)) begin
            fmt_nxt = vst_pkg::VST_ED;
        end else begin
            fmt_nxt = vst_pkg::VST_SD;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            since_ref_r <= 14'h0000;
            line_len_r <= 14'h0000;
            fmt_r <= vst_pkg::VST_SD;
        end else if (!present_s) begin
            since_ref_r <= 14'h0000;
            line_len_r <= 14'h0000;
        end else if (accept) begin
            since_ref_r <= 14'h0000;
            line_len_r <= sat ? 14'h0000 : since_ref_r;
            fmt_r <= fmt_nxt;
        end else if (!sat) begin
            since_ref_r <= since_ref_r + 14'h0001;
        end
    end

    // A tri-level positive tip in the line marks HD; seeing it beats the clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tri_seen_r <= 1'b0;
        end else if (x2_r.tri_pos) begin
            tri_seen_r <= 1'b1;
        end else if (accept) begin
            tri_seen_r <= 1'b0;
        end
    end

    // ****************************************
    // Composite and line sync
    // ****************************************
    logic comp_pin_r;
    logic hs_pin_r;
    logic [11:0] hs_cnt_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            comp_pin_r <= `VST_PIN_IDLE;
        end else begin
            comp_pin_r <= ~x2_r.comp;
        end
    end

    // Fixed width from the leading edge, so the trailing edge is always rebuilt
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hs_pin_r <= `VST_PIN_IDLE;
            hs_cnt_r <= 12'h000;
        end else if (!present_s) begin
            hs_pin_r <= `VST_PIN_IDLE;
            hs_cnt_r <= 12'h000;
        end else if (accept) begin
            hs_pin_r <= 1'b0;
            hs_cnt_r <= hs_width(fmt_nxt) - 12'h001;
        end else if (hs_cnt_r != 12'h000) begin
            hs_cnt_r <= hs_cnt_r - 12'h001;
        end else begin
            hs_pin_r <= 1'b1;
        end
    end

    // ****************************************
    // Field sync and parity
    // ****************************************
    logic [13:0] comp_w_r;
    logic broad;
    logic vstart;
    logic half;
    logic vs_pin_r;
    logic [15:0] vs_cnt_r;
    logic last_half_r;
    logic ilace_r;
    logic par_pin_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            comp_w_r <= 14'h0000;
        end else if (!x2_r.comp) begin
            comp_w_r <= 14'h0000;
        end else if (comp_w_r != 14'h3FFF) begin
            comp_w_r <= comp_w_r + 14'h0001;
        end
    end

    // Broad pulse: sync longer than an eighth of a line
    assign broad = x2_r.comp & (line_len_r != 14'h0000) & (comp_w_r == (line_len_r >> 3));
    assign vstart = broad & vs_pin_r & present_s;
    // Vertical interval starting mid-line marks the even field
    assign half = since_ref_r > ((line_len_r >> 2) + (line_len_r >> 3));

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vs_pin_r <= `VST_PIN_IDLE;
            vs_cnt_r <= 16'h0000;
        end else if (!present_s) begin
            vs_pin_r <= `VST_PIN_IDLE;
            vs_cnt_r <= 16'h0000;
        end else if (vstart) begin
            vs_pin_r <= 1'b0;
            vs_cnt_r <= 16'({2'h0, line_len_r} + {1'h0, line_len_r, 1'h0});
        end else if (vs_cnt_r != 16'h0000) begin
            vs_cnt_r <= vs_cnt_r - 16'h0001;
        end else begin
            vs_pin_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_half_r <= 1'b0;
            ilace_r <= 1'b0;
            par_pin_r <= `VST_PIN_IDLE;
        end else if (vstart) begin
            last_half_r <= half;
            ilace_r <= half ^ last_half_r;
            par_pin_r <= ~(half ^ last_half_r) | ~half;
        end else if (!ilace_r) begin
            par_pin_r <= 1'b1;
        end
    end

    // ****************************************
    // Line count word
    // ****************************************
    logic [10:0] line_cnt_r;
    logic [10:0] word_r;
    logic [3:0] hidx_r;
    logic [3:0] hidx_nxt;
    logic ser_pin_r;

    assign hidx_nxt = (hidx_r == 4'hF) ? hidx_r : hidx_r + 4'h1;

    // Lines under field sync are left out, so the word runs about three low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            line_cnt_r <= 11'h000;
            word_r <= 11'h000;
        end else if (vstart) begin
            word_r <= line_cnt_r;
            line_cnt_r <= 11'h000;
        end else if (accept && vs_pin_r && line_cnt_r != 11'h7FF) begin
            line_cnt_r <= line_cnt_r + 11'h001;
        end
    end

    // Pin holds between bit slots; receiver must not read it there
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hidx_r <= 4'hF;
            ser_pin_r <= 1'b0;
        end else if (vstart) begin
            hidx_r <= 4'h0;
        end else if (accept) begin
            hidx_r <= hidx_nxt;
            if (hidx_nxt >= `VST_FIRST_BIT && hidx_nxt <= `VST_LAST_BIT) begin
                ser_pin_r <= word_r[4'(`VST_LAST_BIT - hidx_nxt)];
            end
        end
    end

    // ****************************************
    // Back porch gate
    // ****************************************
    vst_pkg::vst_bp_t bp_st_r;
    logic [11:0] bp_cnt_r;
    logic bp_pin_r;
    logic bp_trig;
    logic vint;

    assign bp_trig = (fmt_r == vst_pkg::VST_HD) ? tri_trail : comp_trail;
    assign vint = hidx_r < `VST_VINT_LINES;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bp_st_r <= vst_pkg::BP_IDLE;
            bp_cnt_r <= 12'h000;
            bp_pin_r <= `VST_PIN_IDLE;
        end else if (!present_s) begin
            bp_st_r <= vst_pkg::BP_IDLE;
            bp_cnt_r <= 12'h000;
            bp_pin_r <= `VST_PIN_IDLE;
        end else begin
            case (bp_st_r)
                vst_pkg::BP_IDLE: begin
                    if (bp_trig) begin
                        bp_st_r <= vst_pkg::BP_WAIT;
                        bp_cnt_r <= bp_delay(fmt_r) - 12'h001;
                    end
                end
                vst_pkg::BP_WAIT: begin
                    if (bp_cnt_r != 12'h000) begin
                        bp_cnt_r <= bp_cnt_r - 12'h001;
                    end else begin
                        bp_st_r <= vst_pkg::BP_LOW;
                        bp_pin_r <= 1'b0;
                        bp_cnt_r <= bp_width(fmt_r, vint) - 12'h001;
                    end
                end
                vst_pkg::BP_LOW: begin
                    if (bp_cnt_r != 12'h000) begin
                        bp_cnt_r <= bp_cnt_r - 12'h001;
                    end else begin
                        bp_st_r <= vst_pkg::BP_IDLE;
                        bp_pin_r <= 1'b1;
                    end
                end
                default: begin
                    bp_st_r <= vst_pkg::BP_IDLE;
                    bp_pin_r <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // Lock tracking
    // ****************************************
    logic [1:0] lock_cnt_r;

    // Any format change restarts the wait for two good fields
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lock_cnt_r <= 2'h0;
        end else if (!present_s || (accept && fmt_nxt != fmt_r)) begin
            lock_cnt_r <= 2'h0;
        end else if (vstart && lock_cnt_r != `VST_LOCK_FIELDS) begin
            lock_cnt_r <= lock_cnt_r + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync_locked <= 1'b0;
        end else begin
            sync_locked <= (lock_cnt_r == `VST_LOCK_FIELDS);
        end
    end

    assign pins = '{composite_sync_pin: comp_pin_r, line_sync_pin: hs_pin_r,
                    field_sync_pin: vs_pin_r, back_porch_gate_pin: bp_pin_r,
                    field_parity_pin: par_pin_r, line_count_serial_pin: ser_pin_r};

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_idle_high;
        !present_s |=> hs_pin_r && vs_pin_r && bp_pin_r;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("outputs not high without input");

    property p_comp_follow;
        $rose(x2_r.comp) |=> !comp_pin_r;
    endproperty
    a_comp_follow: assert property (p_comp_follow) else $error("composite did not follow sync");

    property p_hs_lead;
        accept |=> $fell(hs_pin_r);
    endproperty
    a_hs_lead: assert property (p_hs_lead) else $error("line sync did not fall on reference");

    property p_hs_width;
        ($fell(hs_pin_r) && present_s) |=> (!hs_pin_r || !present_s)[*8];
    endproperty
    a_hs_width: assert property (p_hs_width) else $error("line sync pulse too short");

    property p_vs_width;
        ($fell(vs_pin_r) && present_s) |=> (!vs_pin_r || !present_s)[*8];
    endproperty
    a_vs_width: assert property (p_vs_width) else $error("field sync pulse too short");

    property p_bp_width;
        ($fell(bp_pin_r) && present_s) |=> (!bp_pin_r || !present_s)[*8];
    endproperty
    a_bp_width: assert property (p_bp_width) else $error("porch gate pulse too short");

    property p_par_edge;
        $changed(par_pin_r) |-> $fell(vs_pin_r);
    endproperty
    a_par_edge: assert property (p_par_edge) else $error("field flag moved off field sync");

    property p_par_prog;
        !par_pin_r |-> ilace_r;
    endproperty
    a_par_prog: assert property (p_par_prog) else $error("field flag low for progressive");

    property p_ser_edge;
        $changed(ser_pin_r) |-> $fell(hs_pin_r);
    endproperty
    a_ser_edge: assert property (p_ser_edge) else $error("serial bit moved off line sync");

    property p_word_latch;
        vstart |=> word_r == $past(line_cnt_r) && line_cnt_r == 11'h000;
    endproperty
    a_word_latch: assert property (p_word_latch) else $error("line count not latched");

endmodule
`default_nettype wire

// >>> tb/vst_fmt_rx.sv
// Far-side receiver model: decodes the serial line count word.
// Assumes the line sync, field sync and serial pins of the sync timing block.
`timescale 1ns/1ns
`default_nettype none
module vst_fmt_rx #(
    parameter int SAMPLE_NS = 1000
) (
    input wire logic line_sync_pin,
    input wire logic field_sync_pin,
    input wire logic line_count_serial_pin,
    input wire logic sync_locked,
    output logic [10:0] word,
    output int words
);
    // ****
    // Decoder
    // ****
    logic hs_rise;
    logic [10:0] shift;
    int idx = 99;
    assign hs_rise = ~line_sync_pin;
    initial begin
        word = 11'h000;
        words = 0;
        shift = 11'h000;
    end
    always @(negedge field_sync_pin) begin
        idx = 0;
    end
    // Trailing edges are rebuilt from a fixed count on every line, so never used
    always @(posedge hs_rise) begin
        idx = idx + 1;
        if (idx >= 3 && idx <= 13) begin
            // Sampling SAMPLE_NS after the leading edge keeps clear of bit changes
            #(SAMPLE_NS);
            shift = {shift[9:0], line_count_serial_pin};
            if (idx == 13 && sync_locked) begin
                word = shift;
                words = words + 1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the sync timing block.
// Assumes the block, its package and header, and the receiver model.
`timescale 1ns/1ns
`default_nettype none
`include "vst_params.svh"
module tb_top;
    // ****
    // Signals
    // ****
    localparam int LINE_P = 130;
    localparam int LINE_CLK = 390;
    logic clk;
    logic slicer_clk;
    logic resetn;
    logic hd_mode;
    logic mon_en;
    vst_pkg::vst_slice_t slice_in;
    vst_pkg::vst_pins_t pins;
    logic sync_locked;
    logic [10:0] rx_word;
    int rx_words;
    int err_count = 0;
    int compares = 0;
    int wid [4];
    int run [4];
    logic [3:0] pv;
    logic [3:0] pv_r = 4'hF;
    logic par_r = 1'b1;

    vst_sync_timing i_dut (.clk(clk), .resetn(resetn), .slicer_clk(slicer_clk), .slice_in(slice_in),
        .pins(pins), .sync_locked(sync_locked));
    vst_fmt_rx i_rx (.line_sync_pin(pins.line_sync_pin), .field_sync_pin(pins.field_sync_pin),
        .line_count_serial_pin(pins.line_count_serial_pin), .sync_locked(sync_locked),
        .word(rx_word), .words(rx_words));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Odd offset keeps the slicer clock edges off the core clock edges
    initial begin
        slicer_clk = 1'b0;
        #7;
        forever #15 slicer_clk = ~slicer_clk;
    end

    // ****
    // Pulse width monitor
    // ****
    assign pv = {pins.composite_sync_pin, pins.line_sync_pin, pins.field_sync_pin, pins.back_porch_gate_pin};
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (pv[i] === 1'b1 && pv_r[i] === 1'b0) wid[i] = run[i];
            run[i] = (pv[i] === 1'b1) ? 0 : run[i] + 1;
        end
        if (mon_en && pins.field_parity_pin !== par_r) chk_bit(pv_r[1] & ~pv[1], 1'b1);
        par_r = pins.field_parity_pin;
        pv_r = pv;
    end

    // ****
    // Compare and stimulus tasks
    // ****
    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [10:0] got, input logic [10:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic chk_near(input int got, input int exp, input int tol);
        compares++;
        if (got < exp - tol || got > exp + tol) begin
            err_count++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge slicer_clk);
        #2;
    endtask
    // Mode 0 plain line, 1 broad pulse at line start, 2 broad pulse at mid-line
    task automatic gen_line(input int mode);
        int tip;
        tip = (mode == 1) ? 40 : 10;
        slice_in.ref50 = 1'b1;
        slice_in.comp = 1'b1;
        tick(tip);
        slice_in.ref50 = 1'b0;
        slice_in.comp = 1'b0;
        slice_in.tri_pos = hd_mode;
        tick(5);
        slice_in.tri_pos = 1'b0;
        if (mode == 2) begin
            tick(50);
            slice_in.ref50 = 1'b1;
            slice_in.comp = 1'b1;
            tick(40);
            slice_in.ref50 = 1'b0;
            slice_in.comp = 1'b0;
            tick(LINE_P - 105);
        end else begin
            tick(LINE_P - tip - 5);
        end
    endtask
    task automatic gen_field(input int mode, input int n);
        gen_line(mode);
        repeat (n - 1) gen_line(0);
    endtask

    // ****
    // Scenarios
    // ****
    task automatic t_idle;
        chk_bit(pins.line_sync_pin, 1'b1);
        chk_bit(pins.field_sync_pin, 1'b1);
        chk_bit(pins.back_porch_gate_pin, 1'b1);
        chk_bit(sync_locked, 1'b0);
        $display("test idle done");
    endtask
    task automatic t_prog;
        slice_in.present = 1'b1;
        repeat (3) gen_line(0);
        gen_field(1, 16);
        chk_bit(sync_locked, 1'b0);
        gen_field(1, 16);
        chk_bit(sync_locked, 1'b1);
        mon_en = 1'b1;
        gen_field(1, 16);
        gen_field(1, 16);
        chk_word(rx_word, 11'h00D);
        chk_bit(pins.field_parity_pin, 1'b1);
        chk_near(wid[2], `VST_HS_ED_CYC, 1);
        chk_near(wid[0], `VST_BP_SHORT_CYC, 1);
        chk_near(wid[1], 3 * LINE_CLK + 1, 3);
        chk_near(wid[3], 30, 3);
        $display("test progressive done");
    endtask
    task automatic t_inter;
        gen_field(2, 16);
        chk_bit(pins.field_parity_pin, 1'b0);
        gen_field(1, 16);
        chk_bit(pins.field_parity_pin, 1'b1);
        gen_field(2, 16);
        chk_bit(pins.field_parity_pin, 1'b0);
        chk_word(rx_word, 11'h00D);
        $display("test interlaced done");
    endtask
    task automatic t_hd;
        hd_mode = 1'b1;
        gen_field(1, 20);
        chk_bit(sync_locked, 1'b0);
        gen_field(1, 20);
        gen_field(1, 20);
        chk_bit(sync_locked, 1'b1);
        chk_word(rx_word, 11'h011);
        chk_near(wid[2], `VST_HS_HD_CYC, 1);
        chk_near(wid[0], `VST_BP_HD_CYC, 1);
        $display("test high definition done");
    endtask
    task automatic t_loss;
        int n;
        mon_en = 1'b0;
        slice_in = 4'h0;
        n = 0;
        while (sync_locked !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n == 200) begin
            err_count++;
            finish_test();
        end
        repeat (3) @(posedge clk);
        #2;
        chk_bit(pins.line_sync_pin, 1'b1);
        chk_bit(pins.field_sync_pin, 1'b1);
        chk_bit(pins.back_porch_gate_pin, 1'b1);
        $display("test input loss done");
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ****
    // Main sequence
    // ****
    initial begin
        slice_in = 4'h0;
        hd_mode = 1'b0;
        mon_en = 1'b0;
        resetn = 1'b0;
        foreach (run[i]) begin
            run[i] = 0;
            wid[i] = 0;
        end
        // Long enough to cover two slicer edges as well
        repeat (7) @(posedge clk);
        #2;
        resetn = 1'b1;
        repeat (20) @(posedge clk);
        #2;
        t_idle();
        t_prog();
        t_inter();
        t_hd();
        t_loss();
        finish_test();
    end
endmodule
`default_nettype wire
